// [rtl/dpma_host.sv]
// Host controller for one port of the dual-port mailbox memory, ordered over AXI4-Lite.
// Assumes an asynchronous device port on the pins and a single 100 MHz clock.
`timescale 1ns/1ps
module dpma_host #(
    parameter bit LEFT_SIDE = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        s_axil_awvalid_i,
    output logic             s_axil_awready_o,
    input  wire logic [7:0]  s_axil_awaddr_i,
    input  wire logic        s_axil_wvalid_i,
    output logic             s_axil_wready_o,
    input  wire logic [31:0] s_axil_wdata_i,
    input  wire logic [3:0]  s_axil_wstrb_i,
    output logic             s_axil_bvalid_o,
    input  wire logic        s_axil_bready_i,
    output logic [1:0]       s_axil_bresp_o,
    input  wire logic        s_axil_arvalid_i,
    output logic             s_axil_arready_o,
    input  wire logic [7:0]  s_axil_araddr_i,
    output logic             s_axil_rvalid_o,
    input  wire logic        s_axil_rready_i,
    output logic [31:0]      s_axil_rdata_o,
    output logic [1:0]       s_axil_rresp_o,
    output logic             chip_enable_n_o,
    output logic             token_select_n_o,
    output logic             rw_n_o,
    output logic             oe_n_o,
    output logic [15:0]      addr_o,
    output logic [7:0]       dq_o,
    output logic             dq_oe_n_o,
    input  wire logic [7:0]  dq_i,
    input  wire logic        collision_n_i,
    input  wire logic        mailbox_flag_n_i
);

    localparam logic [15:0] OWN_BOX = LEFT_SIDE ? dpma_pkg::LEFT_BOX_ADDR
                                                : dpma_pkg::RIGHT_BOX_ADDR;

    dpma_pkg::dpma_host_t q;
    dpma_pkg::dpma_host_t n;
    logic [31:0]          rd_mux;

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axil_araddr_i)
            dpma_pkg::REG_CTRL:  rd_mux = {29'h0, q.op_tok, q.op_wr, q.start_pend};
            dpma_pkg::REG_ADDR:  rd_mux = {16'h0, q.op_addr};
            dpma_pkg::REG_WDATA: rd_mux = {24'h0, q.op_wdata};
            dpma_pkg::REG_RDATA: rd_mux = {24'h0, q.rdata};
            dpma_pkg::REG_STATUS: begin
                rd_mux[dpma_pkg::STAT_ACTIVE] = (q.state != dpma_pkg::S_IDLE) | q.start_pend;
                rd_mux[dpma_pkg::STAT_MAIL]   = ~q.flag_s2;
                rd_mux[dpma_pkg::STAT_COLL]   = q.col_seen;
                rd_mux[dpma_pkg::STAT_INIT]   = ~q.init_pend;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        // Pins come from another domain: two flops before use
        n.dq_s1   = dq_i;
        n.dq_s2   = q.dq_s1;
        n.col_s1  = collision_n_i;
        n.col_s2  = q.col_s1;
        n.flag_s1 = mailbox_flag_n_i;
        n.flag_s2 = q.flag_s1;

        // AXI write channels, taken in either order
        if (q.bvalid && s_axil_bready_i) begin
            n.bvalid = 1'b0;
        end
        if (s_axil_awvalid_i && q.awready) begin
            n.aw_got  = 1'b1;
            n.aw_addr = s_axil_awaddr_i;
        end
        if (s_axil_wvalid_i && q.wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axil_wdata_i;
            n.wstrb = s_axil_wstrb_i;
        end
        if (q.aw_got && q.w_got) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = dpma_pkg::RESP_OKAY;
            case (q.aw_addr)
                dpma_pkg::REG_CTRL: begin
                    // A start while a cycle runs is dropped; software polls STATUS
                    if (q.wstrb[0] && q.wdata[dpma_pkg::CTRL_START] && !q.start_pend
                        && q.state == dpma_pkg::S_IDLE) begin
                        n.start_pend = 1'b1;
                        n.op_wr      = q.wdata[dpma_pkg::CTRL_WRITE];
                        n.op_tok     = q.wdata[dpma_pkg::CTRL_TOKEN];
                    end
                end
                dpma_pkg::REG_ADDR: begin
                    if (q.wstrb[0]) n.op_addr[7:0]  = q.wdata[7:0];
                    if (q.wstrb[1]) n.op_addr[15:8] = q.wdata[15:8];
                end
                dpma_pkg::REG_WDATA: begin
                    if (q.wstrb[0]) n.op_wdata = q.wdata[7:0];
                end
                dpma_pkg::REG_RDATA: ;
                dpma_pkg::REG_STATUS: begin
                    if (q.wstrb[0] && q.wdata[dpma_pkg::STAT_COLL]) n.col_seen = 1'b0;
                end
                default: n.bresp = dpma_pkg::RESP_SLVERR;
            endcase
        end

        // AXI read channel
        if (q.rvalid && s_axil_rready_i) begin
            n.rvalid = 1'b0;
        end
        if (s_axil_arvalid_i && q.arready) begin
            n.rvalid    = 1'b1;
            n.rdata_bus = rd_mux;
            n.rresp     = (s_axil_araddr_i <= dpma_pkg::REG_STATUS && s_axil_araddr_i[1:0] == 2'h0)
                          ? dpma_pkg::RESP_OKAY : dpma_pkg::RESP_SLVERR;
        end

        // Port sequencer; collision sets below win over the software clear above
        case (q.state)
            dpma_pkg::S_IDLE: begin
                if (q.init_pend || q.start_pend) begin
                    n.pin = dpma_pkg::PIN_IDLE;
                    if (q.init_pend) begin
                        // Read own mailbox once so its flag starts inactive
                        n.op_wr   = 1'b0;
                        n.op_tok  = 1'b0;
                        n.pin.addr = OWN_BOX;
                        n.pin.ce_n = 1'b0;
                    end else if (q.op_tok) begin
                        // Token space: chip enable high, select low, A2..A0 only
                        n.pin.sem_n = 1'b0;
                        n.pin.addr  = {13'h0000, q.op_addr[dpma_pkg::TOKEN_SEL_W-1:0]};
                        n.pin.dq    = {7'h00, q.op_wdata[0]};
                    end else begin
                        n.pin.ce_n = 1'b0;
                        n.pin.addr = q.op_addr;
                        n.pin.dq   = q.op_wdata;
                    end
                    n.pin.dq_oe_n = ~(q.op_wr & ~q.init_pend);
                    n.start_pend  = q.init_pend ? q.start_pend : 1'b0;
                    n.cnt         = dpma_pkg::SETUP_CYC - 4'h1;
                    n.state       = dpma_pkg::S_SETUP;
                end
            end
            dpma_pkg::S_SETUP: begin
                // Address and enable held steady before any strobe
                if (q.cnt != 4'h0) begin
                    n.cnt = q.cnt - 4'h1;
                end else if (q.op_wr && !q.op_tok && !q.col_s2) begin
                    n.col_seen = 1'b1;
                    n.state    = dpma_pkg::S_BLOCKED;
                end else begin
                    n.pin.rw_n = ~q.op_wr;
                    n.pin.oe_n = q.op_wr;
                    n.cnt      = dpma_pkg::STROBE_CYC - 4'h1;
                    n.state    = dpma_pkg::S_STROBE;
                end
            end
            dpma_pkg::S_STROBE: begin
                if (!q.op_tok && !q.col_s2) n.col_seen = 1'b1;
                if (q.op_wr && !q.op_tok && !q.col_s2) begin
                    // The device drops this write, so stop and retry later
                    n.pin.rw_n = 1'b1;
                    n.state    = dpma_pkg::S_BLOCKED;
                end else if (q.cnt != 4'h0) begin
                    n.cnt = q.cnt - 4'h1;
                end else begin
                    n.pin.rw_n = 1'b1;
                    n.pin.oe_n = 1'b1;
                    if (!q.op_wr) n.rdata = q.dq_s2;
                    n.cnt   = dpma_pkg::HOLD_CYC - 4'h1;
                    n.state = dpma_pkg::S_HOLD;
                end
            end
            dpma_pkg::S_HOLD: begin
                if (q.cnt != 4'h0) begin
                    n.cnt = q.cnt - 4'h1;
                end else begin
                    n.pin       = dpma_pkg::PIN_IDLE;
                    n.init_pend = 1'b0;
                    n.state     = dpma_pkg::S_IDLE;
                end
            end
            dpma_pkg::S_BLOCKED: begin
                // Wait for the single collision line (ANDed array-wide if expanded)
                if (q.col_s2) begin
                    n.cnt   = dpma_pkg::SETUP_CYC - 4'h1;
                    n.state = dpma_pkg::S_SETUP;
                end
            end
            default: begin
                n.pin   = dpma_pkg::PIN_IDLE;
                n.state = dpma_pkg::S_IDLE;
            end
        endcase

        n.awready = ~n.aw_got & ~n.bvalid;
        n.wready  = ~n.w_got & ~n.bvalid;
        n.arready = ~n.rvalid;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q           <= '0;
            q.pin       <= dpma_pkg::PIN_IDLE;
            q.init_pend <= 1'b1;
            q.col_s1    <= 1'b1;
            q.col_s2    <= 1'b1;
            q.flag_s1   <= 1'b1;
            q.flag_s2   <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign s_axil_awready_o = q.awready;
    assign s_axil_wready_o  = q.wready;
    assign s_axil_bvalid_o  = q.bvalid;
    assign s_axil_bresp_o   = q.bresp;
    assign s_axil_arready_o = q.arready;
    assign s_axil_rvalid_o  = q.rvalid;
    assign s_axil_rdata_o   = q.rdata_bus;
    assign s_axil_rresp_o   = q.rresp;
    assign chip_enable_n_o  = q.pin.ce_n;
    assign token_select_n_o = q.pin.sem_n;
    assign rw_n_o           = q.pin.rw_n;
    assign oe_n_o           = q.pin.oe_n;
    assign addr_o           = q.pin.addr;
    assign dq_o             = q.pin.dq;
    assign dq_oe_n_o        = q.pin.dq_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_TOKEN_CE_HIGH: assert property (
        !token_select_n_o |-> chip_enable_n_o)
        else $error("token access with chip enable low");
    AST_SETUP_BEFORE_WRITE: assert property (
        $fell(rw_n_o) |-> $past(!chip_enable_n_o || !token_select_n_o, 2)
                          && $stable(addr_o) && (addr_o == $past(addr_o, 2)))
        else $error("write strobe without settled address and enable");
    AST_INIT_CLEAR: assert property (
        $fell(rst_i) |-> ##[1:20] (!oe_n_o && !chip_enable_n_o && addr_o == OWN_BOX))
        else $error("own mailbox not read after reset");
    AST_NO_WRITE_BLOCKED: assert property (
        (!q.col_s2 && !rw_n_o && token_select_n_o) |=> rw_n_o)
        else $error("write strobe kept while collision low");
    AST_STROBE_EXCL: assert property (
        !(!rw_n_o && !oe_n_o) && (rw_n_o || !dq_oe_n_o))
        else $error("strobe conflict on data pins");
    AST_B_HOLD: assert property (
        s_axil_bvalid_o && !s_axil_bready_i |=> s_axil_bvalid_o && $stable(s_axil_bresp_o))
        else $error("write response dropped before ready");

    COV_TOKEN_WRITE: cover property (!token_select_n_o ##1 !rw_n_o);
    COV_MAIL_READ:   cover property (!oe_n_o && addr_o == OWN_BOX && !chip_enable_n_o);
    COV_RETRY:       cover property (q.state == dpma_pkg::S_BLOCKED ##[1:50] !rw_n_o);

endmodule

// [shared/dpma_pkg.sv]
// Constants, register map and carrier types for the dual-port mailbox host controller.
// Assumes one 100 MHz clock and an asynchronous dual-port memory port on the pins.
package dpma_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_SETUP_NS    = 20;
    // Covers slowest access plus the two-flop data synchroniser
    localparam int unsigned T_STROBE_NS   = 80;
    localparam int unsigned T_HOLD_NS     = 10;
    localparam logic [3:0] SETUP_CYC  = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HOLD_CYC   = 4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Memory map of the device port
    // ------------------------------------------------------------
    localparam logic [15:0] LEFT_BOX_ADDR  = 16'hfffe;
    localparam logic [15:0] RIGHT_BOX_ADDR = 16'hffff;
    localparam int unsigned TOKEN_SEL_W    = 3;

    // ------------------------------------------------------------
    // Host registers (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_WRITE = 1;
    localparam int unsigned CTRL_TOKEN = 2;
    localparam int unsigned STAT_ACTIVE = 0;
    localparam int unsigned STAT_MAIL   = 1;
    localparam int unsigned STAT_COLL   = 2;
    localparam int unsigned STAT_INIT   = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_BLOCKED} dpma_state_t;

    typedef struct packed {
        logic        ce_n;
        logic        sem_n;
        logic        rw_n;
        logic        oe_n;
        logic        dq_oe_n;
        logic [15:0] addr;
        logic [7:0]  dq;
    } dpma_pins_t;

    localparam dpma_pins_t PIN_IDLE = '{ce_n: 1'b1, sem_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
                                        dq_oe_n: 1'b1, addr: 16'h0000, dq: 8'h00};

    typedef struct packed {
        dpma_state_t state;
        logic [3:0]  cnt;
        dpma_pins_t  pin;
        logic        start_pend;
        logic        init_pend;
        logic        op_wr;
        logic        op_tok;
        logic [15:0] op_addr;
        logic [7:0]  op_wdata;
        logic [7:0]  rdata;
        logic        col_seen;
        logic [7:0]  dq_s1;
        logic [7:0]  dq_s2;
        logic        col_s1;
        logic        col_s2;
        logic        flag_s1;
        logic        flag_s2;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata_bus;
    } dpma_host_t;

endpackage

// [sim/dpma_dev_model.sv]
// Behavioural two-port memory with mailbox flags, collision arbitration and token latches.
// Assumes the left port is the host under test and the right port is driven by the bench.
`timescale 1ns/1ps
module dpma_dev_model (
    input  wire logic                 rst_i,
    input  wire dpma_pkg::dpma_pins_t l_pins_i,
    input  wire dpma_pkg::dpma_pins_t r_pins_i,
    output logic [7:0]                l_q_o,
    output logic [7:0]                r_q_o,
    output logic                      l_busy_n_o,
    output logic                      r_busy_n_o,
    output logic                      l_flag_n_o,
    output logic                      r_flag_n_o
);
    logic [7:0]           mem [0:65535];
    dpma_pkg::dpma_pins_t c [2];
    dpma_pkg::dpma_pins_t p [2] = '{dpma_pkg::PIN_IDLE, dpma_pkg::PIN_IDLE};
    logic [7:0]           q [2] = '{8'h00, 8'h00};
    logic [7:0]           tq [2];
    logic [1:0]           req [8];
    int                   own [8];
    longint               t_arr [2];
    logic                 busy [2];
    logic                 flag [2] = '{1'b1, 1'b1};
    logic                 match;
    int                   o;
    int                   i;
    // Sampled every nanosecond: fine enough for pins that move on 10 ns edges
    always #1 begin
        c[0] = l_pins_i;
        c[1] = r_pins_i;
        for (int s = 0; s < 2; s++) begin
            if (c[s].ce_n != p[s].ce_n || c[s].addr != p[s].addr) begin
                t_arr[s] = $time;
            end
        end
        match = !c[0].ce_n && !c[1].ce_n && c[0].addr == c[1].addr;
        // Master role, busy pins are outputs; later arrival loses, a tie goes right
        busy[0] = match && t_arr[0] >= t_arr[1];
        busy[1] = match && !busy[0];
        if (rst_i) begin
            flag = '{1'b1, 1'b1};
            own = '{default: 0};
            req = '{default: 2'b00};
        end else begin
            for (int s = 0; s < 2; s++) begin
                o = 1 - s;
                i = int'(c[s].addr[2:0]);
                if (c[s].rw_n && !p[s].rw_n) begin
                    if (!c[s].ce_n && c[s].sem_n && !busy[s]) begin
                        mem[c[s].addr] = c[s].dq;
                        if (c[s].addr == (s == 0 ? 16'hffff : 16'hfffe)) flag[o] = 1'b0;
                    end else if (c[s].ce_n && !c[s].sem_n && !c[s].dq[0]) begin
                        req[i][s] = 1'b1;
                        if (own[i] == 0) own[i] = s + 1;
                    end else if (c[s].ce_n && !c[s].sem_n) begin
                        req[i][s] = 1'b0;
                        if (own[i] == s + 1) own[i] = req[i][o] ? o + 1 : 0;
                    end
                end
                if (!c[s].ce_n && !c[s].oe_n && !busy[s] && (s == 0 || c[s].rw_n)
                    && c[s].addr == (s == 0 ? 16'hfffe : 16'hffff)) flag[s] = 1'b1;
                if (!c[s].sem_n && !c[s].oe_n && (p[s].sem_n || p[s].oe_n)) begin
                    tq[s] = {8{own[i] != s + 1}};
                end
                if (!c[s].ce_n && !c[s].oe_n && c[s].rw_n) q[s] = mem[c[s].addr];
                else if (!c[s].sem_n && !c[s].oe_n) q[s] = tq[s];
                else if (c[s].oe_n && !p[s].oe_n) q[s] = ~q[s];
                p[s] = c[s];
            end
        end
    end
    assign l_q_o = q[0];
    assign r_q_o = q[1];
    assign l_busy_n_o = !busy[0];
    assign r_busy_n_o = !busy[1];
    assign l_flag_n_o = flag[0];
    assign r_flag_n_o = flag[1];
endmodule

// [sim/dpma_host_tb_top.sv]
// Self-checking bench: host on the left port, bench drives the right port directly.
// Assumes the device model above and AXI4-Lite with bready and rready held high.
`timescale 1ns/1ps
module dpma_host_tb_top;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    // Device reset stands for power-up only; a host reset leaves the flags alone
    logic                 dev_rst = 1'b1;
    logic                 awvalid = 1'b0;
    logic                 wvalid = 1'b0;
    logic                 arvalid = 1'b0;
    logic [7:0]           awaddr = 8'h00;
    logic [7:0]           araddr = 8'h00;
    logic [31:0]          wdata = 32'h00000000;
    logic                 awready, wready, bvalid, arready, rvalid;
    logic [1:0]           bresp, rresp;
    logic [31:0]          rdata;
    logic                 ce_n, sem_n, rw_n, oe_n, dq_oe_n, coll_n, busy_r, flag_l, flag_r;
    logic [15:0]          addr;
    logic [7:0]           dq, dq_in, r_q;
    dpma_pkg::dpma_pins_t lp;
    dpma_pkg::dpma_pins_t rp = dpma_pkg::PIN_IDLE;
    int                   n_errors = 0;
    int                   comparisons = 0;
    int                   cyc = 0;
    assign lp = '{ce_n: ce_n, sem_n: sem_n, rw_n: rw_n, oe_n: oe_n, dq_oe_n: dq_oe_n,
                  addr: addr, dq: dq};
    dpma_host #(.LEFT_SIDE(1'b1)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready), .s_axil_awaddr_i(awaddr),
        .s_axil_wvalid_i(wvalid), .s_axil_wready_o(wready), .s_axil_wdata_i(wdata),
        .s_axil_wstrb_i(4'hf), .s_axil_bvalid_o(bvalid), .s_axil_bready_i(1'b1),
        .s_axil_bresp_o(bresp), .s_axil_arvalid_i(arvalid), .s_axil_arready_o(arready),
        .s_axil_araddr_i(araddr), .s_axil_rvalid_o(rvalid), .s_axil_rready_i(1'b1),
        .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp), .chip_enable_n_o(ce_n),
        .token_select_n_o(sem_n), .rw_n_o(rw_n), .oe_n_o(oe_n), .addr_o(addr), .dq_o(dq),
        .dq_oe_n_o(dq_oe_n), .dq_i(dq_in), .collision_n_i(coll_n), .mailbox_flag_n_i(flag_l));
    dpma_dev_model i_dev (.rst_i(dev_rst), .l_pins_i(lp), .r_pins_i(rp), .l_q_o(dq_in),
        .r_q_o(r_q), .l_busy_n_o(coll_n), .r_busy_n_o(busy_r), .l_flag_n_o(flag_l),
        .r_flag_n_o(flag_r));
    // ------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------
    initial forever #5 clk_i = ~clk_i;
    // Whole run needs a few hundred cycles; the ceiling leaves wide margin
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    // ------------------------------------------------------------
    // Bus and pin tasks
    // ------------------------------------------------------------
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        logic [1:0]  r;
        do axr(dpma_pkg::REG_STATUS, s, r); while (s[dpma_pkg::STAT_ACTIVE] !== 1'b0);
    endtask
    task automatic host_start(input logic tok, input logic wr, input logic [15:0] a,
                              input logic [7:0] d);
        logic [1:0] r;
        axw(dpma_pkg::REG_ADDR, {16'h0000, a}, r);
        axw(dpma_pkg::REG_WDATA, {24'h000000, d}, r);
        axw(dpma_pkg::REG_CTRL, {29'h00000000, tok, wr, 1'b1}, r);
    endtask
    task automatic hrd(input logic tok, input logic [15:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        host_start(tok, 1'b0, a, 8'h00);
        wait_idle();
        axr(dpma_pkg::REG_RDATA, d, r);
        chk("host read data", {24'h000000, exp}, d);
    endtask
    task automatic hwr(input logic tok, input logic [15:0] a, input logic [7:0] d);
        host_start(tok, 1'b1, a, d);
        wait_idle();
    endtask
    // The bench stands in for the right processor, address settled before the strobe
    task automatic r_op(input logic tok, input logic wr, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        rp.ce_n <= tok;
        rp.sem_n <= !tok;
        rp.addr <= a;
        rp.dq <= d;
        repeat (2) @(posedge clk_i);
        if (wr) rp.rw_n <= 1'b0;
        else rp.oe_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        q = r_q;
        rp.rw_n <= 1'b1;
        rp.oe_n <= 1'b1;
        @(posedge clk_i);
        rp.ce_n <= 1'b1;
        rp.sem_n <= 1'b1;
        rp.dq <= ~d;
        @(posedge clk_i);
    endtask
    task automatic rrd(input logic tok, input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] q;
        r_op(tok, 1'b0, a, 8'h00, q);
        chk("right read data", {24'h000000, exp}, {24'h000000, q});
    endtask
    task automatic rwr(input logic tok, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        r_op(tok, 1'b1, a, d, q);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        axw(8'h24, 32'h00000001, r);
        chk("bresp", {30'h0, dpma_pkg::RESP_SLVERR}, {30'h0, r});
        axr(8'h20, d, r);
        chk("rresp", {30'h0, dpma_pkg::RESP_SLVERR}, {30'h0, r});
        chk("rdata", 32'h00000000, d);
    endtask
    task automatic t_mailbox();
        logic [31:0] s;
        logic [1:0]  r;
        rwr(1'b0, 16'hfffe, 8'h3c);
        chk("left flag", 1'b0, flag_l);
        axr(dpma_pkg::REG_STATUS, s, r);
        chk("mail pending", 1'b1, s[dpma_pkg::STAT_MAIL]);
        hrd(1'b0, 16'hfffe, 8'h3c);
        chk("left flag", 1'b1, flag_l);
        hwr(1'b0, 16'hffff, 8'ha5);
        chk("right flag", 1'b0, flag_r);
        rrd(1'b0, 16'hffff, 8'ha5);
        chk("right flag", 1'b1, flag_r);
    endtask
    task automatic t_collision();
        logic [31:0] s;
        logic [1:0]  r;
        rwr(1'b0, 16'h0040, 8'h11);
        rp.ce_n <= 1'b0;
        rp.oe_n <= 1'b0;
        host_start(1'b0, 1'b1, 16'h0040, 8'h77);
        repeat (30) @(posedge clk_i);
        axr(dpma_pkg::REG_STATUS, s, r);
        chk("active", 1'b1, s[dpma_pkg::STAT_ACTIVE]);
        chk("coll seen", 1'b1, s[dpma_pkg::STAT_COLL]);
        chk("right busy", 1'b1, busy_r);
        chk("write strobe", 1'b1, rw_n);
        chk("right data", 8'h11, r_q);
        rp.ce_n <= 1'b1;
        rp.oe_n <= 1'b1;
        wait_idle();
        rrd(1'b0, 16'h0040, 8'h77);
        axw(dpma_pkg::REG_STATUS, 32'h00000004, r);
        axr(dpma_pkg::REG_STATUS, s, r);
        chk("coll cleared", 1'b0, s[dpma_pkg::STAT_COLL]);
    endtask
    task automatic t_tokens();
        hwr(1'b1, 16'h0003, 8'hfe);
        hrd(1'b1, 16'h0003, 8'h00);
        rrd(1'b1, 16'h0003, 8'hff);
        hrd(1'b1, 16'h0005, 8'hff);
        rwr(1'b1, 16'h0003, 8'h00);
        rrd(1'b1, 16'h0003, 8'hff);
        hrd(1'b1, 16'h0003, 8'h00);
        hwr(1'b1, 16'h0003, 8'h01);
        rrd(1'b1, 16'h0003, 8'h00);
        hrd(1'b1, 16'h0003, 8'hff);
        rwr(1'b1, 16'h0003, 8'h01);
        rrd(1'b1, 16'h0003, 8'hff);
        hrd(1'b1, 16'h0003, 8'hff);
    endtask
    task automatic t_reset();
        logic [31:0] s;
        logic [1:0]  r;
        rwr(1'b0, 16'hfffe, 8'h5a);
        chk("left flag before reset", 1'b0, flag_l);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        do axr(dpma_pkg::REG_STATUS, s, r); while (s[dpma_pkg::STAT_INIT] !== 1'b1);
        chk("left flag after host reset", 1'b1, flag_l);
        axr(dpma_pkg::REG_STATUS, s, r);
        chk("mail pending after reset", 1'b0, s[dpma_pkg::STAT_MAIL]);
    endtask
    initial begin
        logic [31:0] s;
        logic [1:0]  r;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        dev_rst <= 1'b0;
        do axr(dpma_pkg::REG_STATUS, s, r); while (s[dpma_pkg::STAT_INIT] !== 1'b1);
        chk("left flag after init", 1'b1, flag_l);
        t_unmapped();
        t_mailbox();
        t_collision();
        t_tokens();
        t_reset();
        report_and_stop();
    end
endmodule
